// ### src/led_burst.sv
`timescale 1ns/10ps
`default_nettype none
module led_burst
    import prox_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [7:0] count_i,
    output logic led_o,
    output logic done_o
);
    logic busy, next_busy;
    logic [9:0] cyc, next_cyc;
    logic [7:0] left, next_left;
    logic next_led, next_done;

    // Pulse train: fixed period, fixed on time, count_i pulses
    always_comb begin
        next_busy = busy;
        next_cyc = cyc;
        next_left = left;
        next_done = 1'b0;
        if (!busy) begin
            if (start_i) begin
                next_cyc = '0;
                next_left = count_i;
                next_busy = (count_i != 8'h00);
                next_done = (count_i == 8'h00);
            end
        end else if (cyc == 10'(PULSE_PERIOD_CYC - 1)) begin
            next_cyc = '0;
            next_left = left - 8'h01;
            if (left == 8'h01) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end else begin
            next_cyc = cyc + 10'h001;
        end
        next_led = next_busy && (next_cyc < 10'(PULSE_ON_CYC));
    end

    // Burst registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy <= 1'b0;
            cyc <= '0;
            left <= '0;
            led_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            busy <= next_busy;
            cyc <= next_cyc;
            left <= next_left;
            led_o <= next_led;
            done_o <= next_done;
        end
    end
endmodule
`default_nettype wire

// ### src/prox_filter.sv
`timescale 1ns/10ps
`default_nettype none
module prox_filter
    import prox_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic valid_i,
    input wire logic [15:0] raw_i,
    input wire logic sat_i,
    input wire logic [7:0] offset_i,
    input wire logic [15:0] low_i,
    input wire logic [15:0] high_i,
    input wire logic [3:0] persist_i,
    output logic valid_o,
    output logic [15:0] data_o,
    output logic sat_o,
    output logic event_o
);
    logic [3:0] run, next_run;
    logic [15:0] next_data;
    logic [17:0] diff;
    logic exceed;
    logic [3:0] need;

    // Offset correction with clamping, window test and persistence
    always_comb begin
        diff = {2'b00, raw_i} - {{10{offset_i[7]}}, offset_i};
        if (diff[17]) begin
            next_data = 16'h0000;
        end else if (diff[16]) begin
            next_data = 16'hffff;
        end else begin
            next_data = diff[15:0];
        end
        exceed = (next_data > high_i) || (next_data < low_i);
        need = (persist_i == 4'h0) ? 4'h1 : persist_i;
        next_run = run;
        if (valid_i) begin
            if (!exceed) begin
                next_run = 4'h0;
            end else if (run != 4'hf) begin
                next_run = run + 4'h1;
            end
        end
    end

    // Result registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run <= '0;
            valid_o <= 1'b0;
            data_o <= '0;
            sat_o <= 1'b0;
            event_o <= 1'b0;
        end else begin
            run <= next_run;
            valid_o <= valid_i;
            if (valid_i) begin
                data_o <= next_data;
                sat_o <= sat_i;
            end
            event_o <= valid_i && exceed && (next_run >= need);
        end
    end
endmodule
`default_nettype wire

// ### src/prox_pkg.sv
package prox_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PULSE_PERIOD_NS = 16000;
    localparam int PULSE_ON_NS = 7200;
    localparam int WAIT_STEP_US = 2730;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PULSE_ON_CYC = (PULSE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_STEP_CYC = (WAIT_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam logic [8:0] WAIT_STEPS_FULL = 9'h100;

    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [5:0] ADDR_ENABLE = 6'h00;
    localparam logic [5:0] ADDR_PULSES = 6'h04;
    localparam logic [5:0] ADDR_WAIT = 6'h08;
    localparam logic [5:0] ADDR_LOW_THR = 6'h0c;
    localparam logic [5:0] ADDR_HIGH_THR = 6'h10;
    localparam logic [5:0] ADDR_PERSIST = 6'h14;
    localparam logic [5:0] ADDR_OFFSET = 6'h18;
    localparam logic [5:0] ADDR_STATUS = 6'h1c;
    localparam logic [5:0] ADDR_MASK = 6'h20;
    localparam logic [5:0] ADDR_DATA = 6'h24;

    // ---------------------------------------------------------------
    // Fields and reset values
    // ---------------------------------------------------------------
    localparam int EN_POWER = 0;
    localparam int EN_PROX = 1;
    localparam int EN_WAIT = 2;
    localparam int EN_SLEEP_AFTER_INT = 3;
    localparam int STAT_PROX_INT = 0;
    localparam int STAT_SAT = 1;
    localparam int STAT_VALID = 2;
    localparam int STAT_W = 3;
    localparam int DATA_SAT_BIT = 16;
    localparam logic [7:0] PULSES_RST = 8'h01;
    localparam logic [7:0] WAIT_RST = 8'hff;
    localparam logic [15:0] HIGH_THR_RST = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_BURST = 2'b01,
        ST_CONV = 2'b10,
        ST_WAIT = 2'b11
    } seq_state_e;
endpackage

// ### src/proximity_sense_control.sv
`timescale 1ns/10ps
`default_nettype none
module proximity_sense_control
    import prox_pkg::*;
#(
    parameter int WAIT_STEP_CYCLES = WAIT_STEP_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [5:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [5:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    input wire logic ADC_VALID_I,
    input wire logic [15:0] ADC_COUNT_I,
    input wire logic ADC_SAT_I,
    output logic ADC_START_O,
    output logic LED_SINK_DRIVE_O,
    output logic INT_O,
    output logic INT_OE_O
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [5:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write, do_read;
    logic [31:0] enable_r, pulses_r, wait_r, low_r, high_r, persist_r, offset_r, mask_r;
    logic [31:0] next_enable, next_pulses, next_wait, next_low, next_high;
    logic [31:0] next_persist, next_offset, next_mask;
    logic [STAT_W-1:0] status, next_status;
    logic next_int;
    seq_state_e state, next_state;
    logic [16:0] step_cyc, next_step_cyc;
    logic [8:0] steps, next_steps;
    logic burst_start, next_burst_start, next_adc_start, burst_done;
    logic filt_valid, filt_sat, filt_event;
    logic [15:0] filt_data;
    logic sleep_hold;

    // Known register address
    function automatic logic mapped(input logic [5:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ADDR_DATA);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // ---------------------------------------------------------------
    // Register bus slave
    // ---------------------------------------------------------------

    // Address and data are taken in either order, answer follows both
    always_comb begin
        next_aw_got = aw_got;
        next_aw_addr = aw_addr;
        next_w_got = w_got;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = BVALID_O;
        next_bresp = BRESP_O;
        if (AWVALID_I && AWREADY_O) begin
            next_aw_got = 1'b1;
            next_aw_addr = AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
            next_w_got = 1'b1;
            next_w_data = WDATA_I;
            next_w_strb = WSTRB_I;
        end
        do_write = aw_got && w_got && !BVALID_O;
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (BVALID_O && BREADY_I) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
    end

    // Read channel, one read in flight
    always_comb begin
        do_read = ARVALID_I && ARREADY_O;
        next_rvalid = RVALID_O;
        next_rdata = RDATA_O;
        next_rresp = RRESP_O;
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
            case (ARADDR_I)
                ADDR_ENABLE: next_rdata = enable_r;
                ADDR_PULSES: next_rdata = pulses_r;
                ADDR_WAIT: next_rdata = wait_r;
                ADDR_LOW_THR: next_rdata = low_r;
                ADDR_HIGH_THR: next_rdata = high_r;
                ADDR_PERSIST: next_rdata = persist_r;
                ADDR_OFFSET: next_rdata = offset_r;
                ADDR_STATUS: next_rdata = {{(32-STAT_W){1'b0}}, status};
                ADDR_MASK: next_rdata = mask_r;
                ADDR_DATA: next_rdata = {15'h0000, filt_sat, filt_data};
                default: next_rdata = 32'h0000_0000;
            endcase
        end else if (RVALID_O && RREADY_I) begin
            next_rvalid = 1'b0;
        end
        next_arready = !next_rvalid;
    end

    // Bus handshake registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_got <= 1'b0;
            aw_addr <= '0;
            w_got <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
            BVALID_O <= 1'b0;
            BRESP_O <= RESP_OKAY;
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= '0;
            RRESP_O <= RESP_OKAY;
        end else begin
            aw_got <= next_aw_got;
            aw_addr <= next_aw_addr;
            w_got <= next_w_got;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            AWREADY_O <= next_awready;
            WREADY_O <= next_wready;
            BVALID_O <= next_bvalid;
            BRESP_O <= next_bresp;
            ARREADY_O <= next_arready;
            RVALID_O <= next_rvalid;
            RDATA_O <= next_rdata;
            RRESP_O <= next_rresp;
        end
    end

    // ---------------------------------------------------------------
    // Control registers and status
    // ---------------------------------------------------------------

    // Writable registers, status set wins over clear-on-read
    always_comb begin
        next_enable = enable_r;
        next_pulses = pulses_r;
        next_wait = wait_r;
        next_low = low_r;
        next_high = high_r;
        next_persist = persist_r;
        next_offset = offset_r;
        next_mask = mask_r;
        if (do_write) begin
            case (aw_addr)
                ADDR_ENABLE: next_enable = merge(enable_r, w_data, w_strb) & 32'h0000_000f;
                ADDR_PULSES: next_pulses = merge(pulses_r, w_data, w_strb) & 32'h0000_00ff;
                ADDR_WAIT: next_wait = merge(wait_r, w_data, w_strb) & 32'h0000_00ff;
                ADDR_LOW_THR: next_low = merge(low_r, w_data, w_strb) & 32'h0000_ffff;
                ADDR_HIGH_THR: next_high = merge(high_r, w_data, w_strb) & 32'h0000_ffff;
                ADDR_PERSIST: next_persist = merge(persist_r, w_data, w_strb) & 32'h0000_000f;
                ADDR_OFFSET: next_offset = merge(offset_r, w_data, w_strb) & 32'h0000_00ff;
                ADDR_MASK: next_mask = merge(mask_r, w_data, w_strb) & 32'h0000_0007;
                default: next_mask = mask_r;
            endcase
        end
        next_status = status;
        if (do_read && (ARADDR_I == ADDR_STATUS)) begin
            next_status = '0;
        end
        next_status[STAT_PROX_INT] = next_status[STAT_PROX_INT] | filt_event;
        next_status[STAT_SAT] = next_status[STAT_SAT] | (filt_valid & filt_sat);
        next_status[STAT_VALID] = next_status[STAT_VALID] | filt_valid;
        next_int = |(status & mask_r[STAT_W-1:0]);
    end

    // Register file and interrupt pin
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            enable_r <= '0;
            pulses_r <= {24'h000000, PULSES_RST};
            wait_r <= {24'h000000, WAIT_RST};
            low_r <= '0;
            high_r <= {16'h0000, HIGH_THR_RST};
            persist_r <= '0;
            offset_r <= '0;
            mask_r <= '0;
            status <= '0;
            INT_O <= 1'b0;
            INT_OE_O <= 1'b0;
        end else begin
            enable_r <= next_enable;
            pulses_r <= next_pulses;
            wait_r <= next_wait;
            low_r <= next_low;
            high_r <= next_high;
            persist_r <= next_persist;
            offset_r <= next_offset;
            mask_r <= next_mask;
            status <= next_status;
            INT_O <= 1'b0; // Pin only ever pulled low
            INT_OE_O <= next_int;
        end
    end

    // ---------------------------------------------------------------
    // Measurement sequencer
    // ---------------------------------------------------------------

    // Sleep, burst, conversion, wait; parked after an interrupt if asked
    always_comb begin
        sleep_hold = enable_r[EN_SLEEP_AFTER_INT] &&
                     (status[STAT_PROX_INT] || filt_event);
        next_state = state;
        next_step_cyc = step_cyc;
        next_steps = steps;
        next_burst_start = 1'b0;
        next_adc_start = 1'b0;
        case (state)
            ST_SLEEP: begin
                if (enable_r[EN_POWER] && enable_r[EN_PROX] && !sleep_hold) begin
                    next_state = ST_BURST;
                    next_burst_start = 1'b1;
                end
            end
            ST_BURST: begin
                if (burst_done) begin
                    next_state = ST_CONV;
                    next_adc_start = 1'b1;
                end
            end
            ST_CONV: begin
                if (ADC_VALID_I) begin
                    next_step_cyc = '0;
                    next_steps = WAIT_STEPS_FULL - {1'b0, wait_r[7:0]};
                    next_state = enable_r[EN_WAIT] ? ST_WAIT : ST_SLEEP;
                end
            end
            ST_WAIT: begin
                if (!enable_r[EN_POWER] || sleep_hold) begin
                    next_state = ST_SLEEP;
                end else if (step_cyc == 17'(WAIT_STEP_CYCLES - 1)) begin
                    next_step_cyc = '0;
                    next_steps = steps - 9'h001;
                    if (steps == 9'h001) begin
                        next_state = ST_SLEEP;
                    end
                end else begin
                    next_step_cyc = step_cyc + 17'h00001;
                end
            end
            default: next_state = ST_SLEEP;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= ST_SLEEP;
            step_cyc <= '0;
            steps <= '0;
            burst_start <= 1'b0;
            ADC_START_O <= 1'b0;
        end else begin
            state <= next_state;
            step_cyc <= next_step_cyc;
            steps <= next_steps;
            burst_start <= next_burst_start;
            ADC_START_O <= next_adc_start;
        end
    end

    // ---------------------------------------------------------------
    // LED burst and result filter
    // ---------------------------------------------------------------
    led_burst u_burst (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(burst_start),
        .count_i(pulses_r[7:0]),
        .led_o(LED_SINK_DRIVE_O),
        .done_o(burst_done)
    );

    prox_filter u_filter (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .valid_i(ADC_VALID_I && (state == ST_CONV)),
        .raw_i(ADC_COUNT_I),
        .sat_i(ADC_SAT_I),
        .offset_i(offset_r[7:0]),
        .low_i(low_r[15:0]),
        .high_i(high_r[15:0]),
        .persist_i(persist_r[3:0]),
        .valid_o(filt_valid),
        .data_o(filt_data),
        .sat_o(filt_sat),
        .event_o(filt_event)
    );
endmodule
`default_nettype wire

// ### testbench/afe_model.sv
`timescale 1ns/10ps
`default_nettype none
module afe_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [3:0] delay_i,
    input wire logic [15:0] count_i,
    input wire logic sat_i,
    output logic valid_o,
    output logic [15:0] count_o,
    output logic sat_o
);
    logic [4:0] left;
    // Answer after the chosen delay; data lines toggle while not valid
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left <= 5'h00;
            valid_o <= 1'b0;
            count_o <= 16'h0000;
            sat_o <= 1'b0;
        end else begin
            left <= start_i ? {1'b0, delay_i} + 5'h01 : left - {4'h0, left != 5'h00};
            valid_o <= left == 5'h01;
            count_o <= (left == 5'h01) ? count_i : ~count_o;
            sat_o <= (left == 5'h01) ? sat_i : ~sat_o;
        end
    end
endmodule
`default_nettype wire

// ### testbench/proximity_sense_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module prox_ctrl_checker
    import prox_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic [5:0] AWADDR_I,
    input wire logic WREADY_O,
    input wire logic BVALID_O,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic [5:0] ARADDR_I,
    input wire logic RVALID_O,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0] RRESP_O,
    input wire logic ADC_VALID_I,
    input wire logic ADC_START_O,
    input wire logic LED_SINK_DRIVE_O,
    input wire logic INT_O,
    input wire logic INT_OE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [9:0] on_cnt;
    logic [9:0] gap_cnt;
    logic [3:0] since_clr;
    logic led_q;
    logic conv_seen;
    logic clr_hs;
    // Status read or mask write may lower the interrupt
    assign clr_hs = (ARVALID_I && ARREADY_O && ARADDR_I == ADDR_STATUS)
        || (AWVALID_I && AWREADY_O && AWADDR_I == ADDR_MASK);
    // Pulse width, pulse spacing and time since a clear
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            on_cnt <= 10'h000;
            gap_cnt <= 10'h3ff;
            since_clr <= 4'hf;
            led_q <= 1'b0;
            conv_seen <= 1'b1;
        end else begin
            led_q <= LED_SINK_DRIVE_O;
            on_cnt <= LED_SINK_DRIVE_O ? on_cnt + 10'h001 : 10'h000;
            gap_cnt <= (LED_SINK_DRIVE_O && !led_q) ? 10'h001
                : gap_cnt + {9'h000, gap_cnt != 10'h3ff};
            since_clr <= clr_hs ? 4'h0 : since_clr + {3'h0, since_clr != 4'hf};
            conv_seen <= ADC_START_O || (conv_seen && !(LED_SINK_DRIVE_O && !led_q));
        end
    end
    // --------
    // Checks
    // --------
    AST_LED_ON: assert property ($fell(LED_SINK_DRIVE_O) |-> on_cnt == 10'(PULSE_ON_CYC))
        else $error("LED on time wrong");
    AST_LED_GAP: assert property ($rose(LED_SINK_DRIVE_O) && !conv_seen |->
        gap_cnt == 10'(PULSE_PERIOD_CYC)) else $error("LED period wrong");
    AST_INT_LOW: assert property (INT_O == 1'b0)
        else $error("interrupt data not low");
    AST_INT_HOLD: assert property ($fell(INT_OE_O) |-> since_clr <= 4'h6)
        else $error("interrupt dropped without clear");
    AST_INT_CAUSE: assert property ($rose(INT_OE_O) |-> $past(ADC_VALID_I, 3))
        else $error("interrupt without result");
    AST_START_ONE: assert property (ADC_START_O |=> !ADC_START_O)
        else $error("start pulse too long");
    AST_WR_BUSY: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while busy");
    AST_RD_ANS: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
        else $error("read answer late");
    AST_RD_BAD: assert property (ARVALID_I && ARREADY_O && ARADDR_I > ADDR_DATA |=>
        RRESP_O == RESP_SLVERR && RDATA_O == 32'h0) else $error("unmapped read wrong");
    cover property ($rose(INT_OE_O));
    cover property (ADC_START_O);
    cover property (RVALID_O && RRESP_O == RESP_SLVERR);
endmodule
bind proximity_sense_control prox_ctrl_checker chk_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WREADY_O(WREADY_O),
    .BVALID_O(BVALID_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I),
    .RVALID_O(RVALID_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .ADC_VALID_I(ADC_VALID_I),
    .ADC_START_O(ADC_START_O), .LED_SINK_DRIVE_O(LED_SINK_DRIVE_O), .INT_O(INT_O),
    .INT_OE_O(INT_OE_O));
`default_nettype wire

// ### testbench/proximity_sense_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module proximity_sense_control_tb_top
    import prox_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
    logic rre = 1'b0, asat = 1'b0, led_q = 1'b0;
    logic awr, wrd, bv, rv, arr, led, start, av, sat_l, oe, int_l;
    logic [5:0] awa = 6'h00, ara = 6'h00;
    logic [31:0] wd = 32'h0, rdata, n0;
    logic [31:0] rises = 0, since = 0, gap = 0, starts = 0;
    logic [3:0] dly = 4'h3;
    logic [15:0] acnt = 16'h00cc, cnt_l;
    logic [1:0] bresp, rresp;
    int bad_count = 0, checks = 0;

    proximity_sense_control #(.WAIT_STEP_CYCLES(20)) dut_u (.CLK_I(clk), .RST_B_I(rst_b),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wrd),
        .WDATA_I(wd), .WSTRB_I(4'hf), .BVALID_O(bv), .BREADY_I(bre), .BRESP_O(bresp),
        .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rre),
        .RDATA_O(rdata), .RRESP_O(rresp), .ADC_VALID_I(av), .ADC_COUNT_I(cnt_l),
        .ADC_SAT_I(sat_l), .ADC_START_O(start), .LED_SINK_DRIVE_O(led), .INT_O(int_l),
        .INT_OE_O(oe));
    afe_model afe_u (.clk_i(clk), .rst_b_i(rst_b), .start_i(start), .delay_i(dly),
        .count_i(acnt), .sat_i(asat), .valid_o(av), .count_o(cnt_l), .sat_o(sat_l));

    always #12.5 clk = ~clk;
    // Count LED pulses, their spacing and conversion starts
    always @(posedge clk) begin
        led_q <= led;
        since <= (led && !led_q) ? 1 : since + 1;
        if (led && !led_q) gap <= since;
        rises <= av ? 0 : rises + (led && !led_q);
        starts <= starts + start;
    end
    // ---------
    // Tasks
    // ---------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ha, hw;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wrd;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
        end while ((awv && !ha) || (wv && !hw));
        do @(negedge clk); while (!bv);
        chk(bresp, r);
        @(posedge clk);
        bre <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
        logic h;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge clk);
            h = arr;
            @(posedge clk);
        end while (!h);
        arv <= 1'b0;
        do @(negedge clk); while (!rv);
        chk(rdata, e);
        chk(rresp, r);
        @(posedge clk);
        rre <= 1'b0;
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ---------
    // Tests
    // ---------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_PULSES, 32'h1, RESP_OKAY);
        rd(ADDR_WAIT, 32'hff, RESP_OKAY);
        rd(ADDR_HIGH_THR, 32'hffff, RESP_OKAY);
        rd(6'h28, 32'h0, RESP_SLVERR);
        wr(6'h2c, 32'h1, RESP_SLVERR);
        wr(ADDR_PULSES, 32'h3, RESP_OKAY);
        wr(ADDR_OFFSET, 32'h4, RESP_OKAY);
        wr(ADDR_LOW_THR, 32'ha, RESP_OKAY);
        wr(ADDR_HIGH_THR, 32'h64, RESP_OKAY);
        wr(ADDR_PERSIST, 32'h2, RESP_OKAY);
        wr(ADDR_MASK, 32'h1, RESP_OKAY);
        wr(ADDR_ENABLE, 32'h3, RESP_OKAY);
        // High, in window, high, high, in window
        for (int i = 0; i < 5; i++) begin
            do @(negedge clk); while (!av);
            chk(rises, 32'h3);
            chk(gap, PULSE_PERIOD_CYC);
            repeat (4) @(negedge clk);
            chk(oe, i >= 3);
            @(posedge clk);
            acnt <= (i == 0 || i == 3) ? 16'h0036 : 16'h00cc;
            asat <= i == 4;
        end
        do @(negedge clk); while (!av);
        rd(ADDR_DATA, 32'h100c8, RESP_OKAY);
        rd(ADDR_STATUS, 32'h7, RESP_OKAY);
        repeat (3) @(negedge clk);
        chk(oe, 1'b0);
        wr(ADDR_ENABLE, 32'hb, RESP_OKAY);
        dly <= 4'hf;
        do @(negedge clk); while (!av);
        repeat (2500) @(posedge clk);
        n0 = starts;
        repeat (3000) @(posedge clk);
        chk(starts - n0, 32'h0);
        chk(oe, 1'b1);
        chk(int_l, 1'b0);
        rd(ADDR_STATUS, 32'h7, RESP_OKAY);
        do @(negedge clk); while (!av);
        wr(ADDR_ENABLE, 32'h3, RESP_OKAY);
        wr(ADDR_MASK, 32'h0, RESP_OKAY);
        do @(negedge clk); while (!av);
        repeat (4) @(negedge clk);
        chk(oe, 1'b0);
        // Wait mode: two steps between a result and the next burst
        wr(ADDR_WAIT, 32'hfe, RESP_OKAY);
        wr(ADDR_ENABLE, 32'h7, RESP_OKAY);
        do @(negedge clk); while (!av);
        n0 = 0;
        do begin
            @(negedge clk);
            n0++;
        end while (!led);
        // Three cycles to the first pulse plus two wait steps of twenty
        chk(n0, 32'h2b);
        give_verdict();
    end
    // Cut a hang short
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
